// ===== rtl/ncs_pkg.sv
// Package: offsets, field positions, opcodes, defaults and carrier types
// for the configuration store controller.
// Assumes an 8-bit register space with 12-bit addresses on the serial port.
package ncs_pkg;

  localparam int          LIST_LEN       = 23;
  localparam logic [11:0] LIST_FIRST_OFS = 12'hA00;
  localparam logic [11:0] LIST_LAST_OFS  = 12'hA16;
  localparam logic [11:0] BUSY_OFS       = 12'hB00;
  localparam logic [11:0] ERROR_OFS      = 12'hB01;
  localparam logic [11:0] RELOAD_OFS     = 12'hB02;
  localparam logic [11:0] SAVE_OFS       = 12'hB03;
  localparam logic [11:0] APPLY_OFS      = 12'hB10;

  localparam int STATUS_BIT = 0;
  localparam int WREN_BIT   = 0;
  localparam int RELOAD_BIT = 1;
  localparam int SAVE_BIT   = 0;
  localparam int APPLY_BIT  = 0;

  localparam logic       WREN_RST  = 1'b0;
  localparam logic [2:0] SYNC_RST  = 3'h7;
  localparam logic [7:0] OP_APPLY  = 8'h80;
  localparam logic [7:0] OP_END    = 8'hFF;
  localparam int         COUNT_MSB = 6;
  localparam int         HI_MSB    = 3;

  // Data segment = count byte, address high nibble, address low byte
  localparam logic [7:0] LIST_DEFAULT [LIST_LEN] = '{
    8'h7F, 8'h00, 8'h00,  8'h7F, 8'h00, 8'h7F,  8'h7F, 8'h00, 8'hFE,
    8'h7F, 8'h01, 8'h7D,  8'h36, 8'h01, 8'hFC,  8'h80, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF,  8'hFF, 8'hFF};

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ncs_reg_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ncs_nvm_req_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ncs_buf_req_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_FETCH = 7'h02,
    ST_TAKE  = 7'h04,
    ST_BYTE  = 7'h08,
    ST_NVM   = 7'h10,
    ST_ADV   = 7'h20,
    ST_FIN   = 7'h40
  } ncs_state_t;

endpackage : ncs_pkg

// ===== rtl/ncs_list_mem.sv
// Segment list storage: one write port, one registered read port.
// Assumes the owner arbitrates the single read address.
`timescale 1ns/10ps
module ncs_list_mem #(
  parameter int DEPTH = ncs_pkg::LIST_LEN,
  parameter int AW    = 5
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  // Reset loads the full-transfer list so a fresh part saves everything
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ncs_pkg::LIST_DEFAULT[i];  // [RQ5]
      end
      rdata <= 8'h00;
    end else begin
      if (we && (int'(waddr) < DEPTH)) begin
        mem[waddr] <= wdata;
      end
      rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : ncs_pkg::OP_END;
    end
  end

endmodule : ncs_list_mem

// ===== rtl/ncs_config_store.sv
// Configuration store controller: apply strobe, segment list, save,
// reload and status for the nonvolatile configuration store.
// Assumes a serial port decoder issuing one-cycle register requests on mclk,
// a store answering each request with a one-cycle ack, and buffer reads valid
// one cycle after the buffer address settles.
`timescale 1ns/10ps
// Behaviour
// RQ1: Host writes one to copy buffers to active
// RQ2: Apply strobe clears itself after the copy
// RQ3: List holds segment start address and count
// RQ4: List also accepts apply and end opcodes
// RQ5: Default list moves everything, then applies
// RQ6: Busy bit reads one during transfer
// RQ7: Error bit flags bad data from store
// RQ8: Reload bit with pin low soft-resets (the code refuses it while busy)
// RQ9: Reload bit clears on next clock
// RQ10: Store writes blocked until write enable set
// RQ11: Save bit starts save, clears when done
// RQ12: Walk list in order until end marker
module ncs_config_store #(
  parameter int LIST_DEPTH = ncs_pkg::LIST_LEN,
  parameter int IDXW       = 5
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire ncs_pkg::ncs_reg_req_t regReq,
  output logic      [7:0]           regRdata,
  output logic                      regRdValid,
  input  wire logic                 storeSelect_n,
  output ncs_pkg::ncs_nvm_req_t      nvmOut,
  input  wire logic                 nvmAck,
  input  wire logic [7:0]           nvmRdata,
  output ncs_pkg::ncs_buf_req_t      bufOut,
  input  wire logic [7:0]           bufRdata,
  output logic                      applyPulse,
  output logic                      softResetPulse
);

  function automatic logic inList(input logic [11:0] a);
    return (a >= ncs_pkg::LIST_FIRST_OFS) && (a <= ncs_pkg::LIST_LAST_OFS);
  endfunction : inList

  function automatic logic [IDXW-1:0] listIdxOf(input logic [11:0] a);
    logic [11:0] d;
    d = a - ncs_pkg::LIST_FIRST_OFS;
    return d[IDXW-1:0];
  endfunction : listIdxOf

  ncs_pkg::ncs_state_t   state,     next_state;
  ncs_pkg::ncs_nvm_req_t next_nvmOut;
  ncs_pkg::ncs_buf_req_t next_bufOut;
  logic [IDXW-1:0] listIdx,     next_listIdx;
  logic [1:0]      fieldSel,    next_fieldSel;
  logic [6:0]      byteCount,   next_byteCount;
  logic [11:0]     curAddr,     next_curAddr;
  logic [7:0]      sum,         next_sum;
  logic            saving,      next_saving;
  logic            wrEnable,    next_wrEnable;
  logic            reloadBit,   next_reloadBit;
  logic            errorFlag,   next_errorFlag;
  logic            pendLoad,    next_pendLoad;
  logic            next_applyPulse;
  logic            next_softResetPulse;
  logic [2:0]      selSync,     next_selSync;
  logic            selLow,      next_selLow;
  logic            rdPend,      next_rdPend;
  logic [11:0]     rdAddrQ,     next_rdAddrQ;
  logic            rdListOk,    next_rdListOk;
  logic [7:0]      next_regRdata;
  logic            busyNow;
  logic            memWe;
  logic [IDXW-1:0] memRaddr;
  logic [7:0]      memRdata;
  logic [7:0]      entry;

  assign busyNow  = (state != ncs_pkg::ST_IDLE) || pendLoad;
  // Host edits to the list are dropped while a transfer walks it
  assign memWe    = regReq.wr && inList(regReq.addr) && !busyNow;  // [RQ3]
  assign memRaddr = (state == ncs_pkg::ST_FETCH) ? listIdx : listIdxOf(regReq.addr);
  assign entry    = memRdata;

  ncs_list_mem #(.DEPTH(LIST_DEPTH), .AW(IDXW)) u_list (
    .mclk  (mclk),
    .rst_n (rst_n),
    .we    (memWe),
    .waddr (listIdxOf(regReq.addr)),
    .wdata (regReq.wdata),
    .raddr (memRaddr),
    .rdata (memRdata)
  );

  // Pin synchroniser and register read path
  always_comb begin
    next_selSync  = {selSync[1:0], storeSelect_n};
    next_selLow   = selLow;
    if (selSync[1] == selSync[2]) begin
      next_selLow = !selSync[2];
    end
    next_rdPend   = regReq.rd;
    next_rdAddrQ  = regReq.rd ? regReq.addr : rdAddrQ;
    next_rdListOk = regReq.rd ? (state != ncs_pkg::ST_FETCH) : rdListOk;
    next_regRdata = regRdata;
    if (rdPend) begin
      next_regRdata = 8'h00;
      if (inList(rdAddrQ)) begin
        next_regRdata = rdListOk ? memRdata : 8'h00;
      end else if (rdAddrQ == ncs_pkg::BUSY_OFS) begin
        next_regRdata[ncs_pkg::STATUS_BIT] = busyNow;  // [RQ6]
      end else if (rdAddrQ == ncs_pkg::ERROR_OFS) begin
        next_regRdata[ncs_pkg::STATUS_BIT] = errorFlag;  // [RQ7]
      end else if (rdAddrQ == ncs_pkg::RELOAD_OFS) begin
        next_regRdata[ncs_pkg::RELOAD_BIT] = reloadBit;
        next_regRdata[ncs_pkg::WREN_BIT]   = wrEnable;
      end else if (rdAddrQ == ncs_pkg::SAVE_OFS) begin
        next_regRdata[ncs_pkg::SAVE_BIT] = saving;  // [RQ11]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selSync    <= ncs_pkg::SYNC_RST;
      selLow     <= 1'b0;
      rdPend     <= 1'b0;
      rdAddrQ    <= 12'h000;
      rdListOk   <= 1'b0;
      regRdata   <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      selSync    <= next_selSync;
      selLow     <= next_selLow;
      rdPend     <= next_rdPend;
      rdAddrQ    <= next_rdAddrQ;
      rdListOk   <= next_rdListOk;
      regRdata   <= next_regRdata;
      regRdValid <= rdPend;
    end
  end

  // Control registers and list walker
  always_comb begin
    next_state          = state;
    next_nvmOut         = nvmOut;
    next_bufOut         = bufOut;
    next_bufOut.we      = 1'b0;
    next_listIdx        = listIdx;
    next_fieldSel       = fieldSel;
    next_byteCount      = byteCount;
    next_curAddr        = curAddr;
    next_sum            = sum;
    next_saving         = saving;
    next_wrEnable       = wrEnable;
    next_reloadBit      = 1'b0;  // [RQ9]
    next_errorFlag      = errorFlag;
    next_pendLoad       = pendLoad;
    next_applyPulse     = 1'b0;  // [RQ2]
    next_softResetPulse = 1'b0;

    if (regReq.wr && (regReq.addr == ncs_pkg::APPLY_OFS) && regReq.wdata[ncs_pkg::APPLY_BIT]) begin
      next_applyPulse = 1'b1;  // [RQ1]
    end
    if (regReq.wr && (regReq.addr == ncs_pkg::RELOAD_OFS)) begin
      next_wrEnable = regReq.wdata[ncs_pkg::WREN_BIT];  // [RQ10]
      if (regReq.wdata[ncs_pkg::RELOAD_BIT]) begin
        next_reloadBit = 1'b1;  // [RQ9]
        // Reload while a transfer runs would corrupt it, so it is refused
        if (selLow && !busyNow) begin
          next_softResetPulse = 1'b1;  // [RQ8]
          next_pendLoad       = 1'b1;  // [RQ8]
        end
      end
    end

    unique case (state)
      ncs_pkg::ST_IDLE: begin
        if (pendLoad || (regReq.wr && (regReq.addr == ncs_pkg::SAVE_OFS)
            && regReq.wdata[ncs_pkg::SAVE_BIT] && wrEnable)) begin  // [RQ10]
          next_saving      = !pendLoad;  // [RQ11]
          next_pendLoad    = 1'b0;
          next_state       = ncs_pkg::ST_FETCH;
          next_listIdx     = '0;
          next_fieldSel    = 2'h0;
          next_sum         = 8'h00;
          next_errorFlag   = 1'b0;
          next_nvmOut.addr = 12'h000;
        end
      end
      ncs_pkg::ST_FETCH: begin
        // Running off the list end acts as an end marker
        if (listIdx == IDXW'(LIST_DEPTH)) begin
          next_state       = ncs_pkg::ST_FIN;  // [RQ12]
          next_nvmOut.req  = 1'b1;
          next_nvmOut.we   = saving;
          next_nvmOut.wdata = sum;
        end else begin
          next_state = ncs_pkg::ST_TAKE;
        end
      end
      ncs_pkg::ST_TAKE: begin
        next_listIdx = listIdx + 1'b1;  // [RQ12]
        next_state   = ncs_pkg::ST_FETCH;
        unique case (fieldSel)
          2'h0: begin
            if (entry == ncs_pkg::OP_END) begin
              // Checksum byte follows the data in the store
              next_state        = ncs_pkg::ST_FIN;  // [RQ12]
              next_nvmOut.req   = 1'b1;
              next_nvmOut.we    = saving;
              next_nvmOut.wdata = sum;
            end else if (entry == ncs_pkg::OP_APPLY) begin
              next_applyPulse = !saving;  // [RQ4] [RQ5]
            end else begin
              next_byteCount = entry[ncs_pkg::COUNT_MSB:0];  // [RQ3]
              next_fieldSel  = 2'h1;
            end
          end
          2'h1: begin
            next_curAddr[11:8] = entry[ncs_pkg::HI_MSB:0];  // [RQ3]
            next_fieldSel      = 2'h2;
          end
          default: begin
            next_curAddr[7:0] = entry;  // [RQ3]
            next_bufOut.addr  = {curAddr[11:8], entry};
            next_fieldSel     = 2'h0;
            if (byteCount != 7'h00) begin
              next_state = ncs_pkg::ST_BYTE;
            end
          end
        endcase
      end
      ncs_pkg::ST_BYTE: begin
        next_nvmOut.req   = 1'b1;
        next_nvmOut.we    = saving;  // [RQ10]
        next_nvmOut.wdata = bufRdata;
        next_state        = ncs_pkg::ST_NVM;
      end
      ncs_pkg::ST_NVM: begin
        if (nvmAck) begin
          next_nvmOut.req  = 1'b0;
          next_nvmOut.addr = nvmOut.addr + 12'h001;
          next_byteCount   = byteCount - 7'h01;
          next_sum         = sum + (saving ? nvmOut.wdata : nvmRdata);
          if (!saving) begin
            next_bufOut.we    = 1'b1;
            next_bufOut.wdata = nvmRdata;
          end
          next_state = ncs_pkg::ST_ADV;
        end
      end
      ncs_pkg::ST_ADV: begin
        next_curAddr     = curAddr + 12'h001;
        next_bufOut.addr = curAddr + 12'h001;
        next_state       = (byteCount == 7'h00) ? ncs_pkg::ST_FETCH : ncs_pkg::ST_BYTE;
      end
      ncs_pkg::ST_FIN: begin
        if (nvmAck) begin
          next_nvmOut.req = 1'b0;
          if (!saving && (nvmRdata != sum)) begin
            next_errorFlag = 1'b1;  // [RQ7]
          end
          next_saving = 1'b0;  // [RQ11]
          next_state  = ncs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state  = ncs_pkg::ST_IDLE;
        next_saving = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ncs_pkg::ST_IDLE;
      nvmOut         <= '0;
      bufOut         <= '0;
      listIdx        <= '0;
      fieldSel       <= 2'h0;
      byteCount      <= 7'h00;
      curAddr        <= 12'h000;
      sum            <= 8'h00;
      saving         <= 1'b0;
      wrEnable       <= ncs_pkg::WREN_RST;
      reloadBit      <= 1'b0;
      errorFlag      <= 1'b0;
      pendLoad       <= 1'b0;
      applyPulse     <= 1'b0;
      softResetPulse <= 1'b0;
    end else begin
      state          <= next_state;
      nvmOut         <= next_nvmOut;
      bufOut         <= next_bufOut;
      listIdx        <= next_listIdx;
      fieldSel       <= next_fieldSel;
      byteCount      <= next_byteCount;
      curAddr        <= next_curAddr;
      sum            <= next_sum;
      saving         <= next_saving;
      wrEnable       <= next_wrEnable;
      reloadBit      <= next_reloadBit;
      errorFlag      <= next_errorFlag;
      pendLoad       <= next_pendLoad;
      applyPulse     <= next_applyPulse;
      softResetPulse <= next_softResetPulse;
    end
  end

  apply_write_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ1]
    regReq.wr && regReq.addr == ncs_pkg::APPLY_OFS && regReq.wdata[ncs_pkg::APPLY_BIT]
    |=> applyPulse)
    else $error("apply write did not pulse");

  apply_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ2]
    applyPulse && !$past(applyPulse) && state == ncs_pkg::ST_IDLE && !regReq.wr
    |=> !applyPulse)
    else $error("apply strobe stuck");

  end_marker_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ12]
    state == ncs_pkg::ST_TAKE && fieldSel == 2'h0 && entry == ncs_pkg::OP_END
    |=> state == ncs_pkg::ST_FIN && nvmOut.req)
    else $error("end marker not honoured");

  load_apply_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ4]
    state == ncs_pkg::ST_TAKE && fieldSel == 2'h0 && entry == ncs_pkg::OP_APPLY && !saving
    |=> applyPulse
    ##1 state == ((listIdx == IDXW'(LIST_DEPTH)) ? ncs_pkg::ST_FIN : ncs_pkg::ST_TAKE))
    else $error("apply opcode ignored on load");

  busy_read_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ6]
    rdPend && rdAddrQ == ncs_pkg::BUSY_OFS
    |=> regRdValid && regRdata[ncs_pkg::STATUS_BIT] == $past(busyNow))
    else $error("busy readback wrong");

  error_set_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ7]
    state == ncs_pkg::ST_FIN && nvmAck && !saving && nvmRdata != sum
    |=> errorFlag && state == ncs_pkg::ST_IDLE)
    else $error("checksum mismatch not flagged");

  soft_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ8]
    regReq.wr && regReq.addr == ncs_pkg::RELOAD_OFS && regReq.wdata[ncs_pkg::RELOAD_BIT]
    && selLow && !busyNow
    |=> softResetPulse ##1 (state == ncs_pkg::ST_FETCH && !saving))
    else $error("reload did not soft reset");

  reload_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ9]
    reloadBit && !(regReq.wr && regReq.addr == ncs_pkg::RELOAD_OFS) |=> !reloadBit)
    else $error("reload bit did not clear");

  write_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ10]
    state == ncs_pkg::ST_IDLE && !pendLoad && !wrEnable |=> !saving)
    else $error("save started while protected");

  save_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)  // [RQ11]
    saving && state == ncs_pkg::ST_FIN && nvmAck |=> !saving && !busyNow)
    else $error("save bit did not clear");

endmodule : ncs_config_store

// ===== sim/ncs_store_model.sv
// Far side: nonvolatile store with adjustable ack latency, plus buffer file.
// Assumes one outstanding store request at a time from the controller.
`timescale 1ns/10ps
module ncs_store_model (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire ncs_pkg::ncs_nvm_req_t nvmOut,
  output logic                       nvmAck,
  output logic      [7:0]            nvmRdata,
  input  wire ncs_pkg::ncs_buf_req_t bufOut,
  output logic      [7:0]            bufRdata,
  input  wire logic [1:0]            lat,
  input  wire logic                  corrupt,
  output logic      [7:0]            wrCount
);
  logic [7:0] mem [1024];
  logic [7:0] bufMem [4096];
  logic [7:0] rdReg;
  logic [1:0] cnt;
  // Inverted outside the ack cycle, so never show the last value
  assign nvmRdata = nvmAck ? rdReg : ~rdReg;
  assign bufRdata = bufMem[bufOut.addr];
  always @(posedge mclk) begin
    if (bufOut.we === 1'b1) bufMem[bufOut.addr] <= bufOut.wdata;
  end
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nvmAck <= 1'b0;
      cnt <= 2'h0;
      rdReg <= 8'h00;
      wrCount <= 8'h00;
    end else begin
      nvmAck <= 1'b0;
      if (nvmOut.req && !nvmAck) begin
        if (cnt >= lat) begin
          nvmAck <= 1'b1;
          cnt <= 2'h0;
          if (nvmOut.we) begin
            mem[nvmOut.addr[9:0]] <= nvmOut.wdata;
            wrCount <= wrCount + 8'h01;
          end else begin
            // Only byte 0 is spoiled, so the checksum cannot cancel it
            rdReg <= mem[nvmOut.addr[9:0]] ^ {7'h00, corrupt && nvmOut.addr == 12'h000};
          end
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
endmodule : ncs_store_model

// ===== sim/tb_ncs_config_store.sv
// Testbench: defaults, apply, save, reload and error paths of the store
// controller. Assumes the store model answers within four cycles.
`timescale 1ns/10ps
module tb_ncs_config_store;
  logic                  mclk;
  logic                  rst_n;
  ncs_pkg::ncs_reg_req_t regReq;
  logic [7:0]            regRdata;
  logic                  regRdValid;
  logic                  storeSelect_n;
  ncs_pkg::ncs_nvm_req_t nvmOut;
  logic                  nvmAck;
  logic [7:0]            nvmRdata;
  ncs_pkg::ncs_buf_req_t bufOut;
  logic [7:0]            bufRdata;
  logic                  applyPulse;
  logic                  softResetPulse;
  logic [1:0]            lat;
  logic                  corrupt;
  logic [7:0]            wrCount;
  logic [7:0]            rdVal;
  logic [7:0]            applyCnt;
  logic [7:0]            softCnt;
  logic [7:0]            lst [11];
  logic [11:0]           seg [2];
  logic [7:0]            cnt [2];
  logic [7:0]            keep [8];
  logic [11:0]           ofs [6];
  int                    num_errors;
  int                    checks;
  integer                seed;

  ncs_config_store #(.LIST_DEPTH(ncs_pkg::LIST_LEN), .IDXW(5)) DUT (
    .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
    .regRdValid(regRdValid), .storeSelect_n(storeSelect_n), .nvmOut(nvmOut),
    .nvmAck(nvmAck), .nvmRdata(nvmRdata), .bufOut(bufOut), .bufRdata(bufRdata),
    .applyPulse(applyPulse), .softResetPulse(softResetPulse));
  ncs_store_model P (
    .mclk(mclk), .rst_n(rst_n), .nvmOut(nvmOut), .nvmAck(nvmAck),
    .nvmRdata(nvmRdata), .bufOut(bufOut), .bufRdata(bufRdata), .lat(lat),
    .corrupt(corrupt), .wrCount(wrCount));

  always @(posedge mclk) begin
    if (applyPulse === 1'b1) applyCnt <= applyCnt + 8'h01;
    if (softResetPulse === 1'b1) softCnt <= softCnt + 8'h01;
  end

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    regReq.wr = 1'b0;
  endtask : wr8

  task automatic rd8(input logic [11:0] a);
    int n;
    @(posedge mclk);
    #1;
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1;
    regReq.rd = 1'b0;
    n = 0;
    while (regRdValid !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    rdVal = (regRdValid === 1'b1) ? regRdata : 8'hXX;
  endtask : rd8

  task automatic waitIdle();
    int n;
    n = 0;
    rd8(ncs_pkg::BUSY_OFS);
    while (rdVal !== 8'h00 && n < 300) begin
      rd8(ncs_pkg::BUSY_OFS);
      n++;
    end
    chk8("busy", 8'h00, rdVal);
  endtask : waitIdle

  task automatic reload();
    wr8(ncs_pkg::RELOAD_OFS, 8'h03);
    waitIdle();
  endtask : reload

  // Buffer address that feeds store byte n, list walked in order
  function automatic logic [11:0] srcAddr(input int n);
    if (n < cnt[0]) return seg[0] + 12'(n);
    return seg[1] + 12'(n - cnt[0]);
  endfunction : srcAddr

  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end

  initial begin
    int i;
    int tot;
    logic [7:0] sum;
    seed = 32'h664B;
    rst_n = 1'b0;
    regReq = '0;
    storeSelect_n = 1'b1;
    lat = 2'h3;
    corrupt = 1'b0;
    applyCnt = 8'h00;
    softCnt = 8'h00;
    num_errors = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (i = 0; i < ncs_pkg::LIST_LEN; i++) begin
      rd8(ncs_pkg::LIST_FIRST_OFS + 12'(i));
      chk8("list default", ncs_pkg::LIST_DEFAULT[i], rdVal);
    end
    wr8(12'h123, 8'hA5);
    ofs = '{ncs_pkg::BUSY_OFS, ncs_pkg::ERROR_OFS, ncs_pkg::RELOAD_OFS,
            ncs_pkg::SAVE_OFS, ncs_pkg::APPLY_OFS, 12'h123};
    for (i = 0; i < 6; i++) begin
      rd8(ofs[i]);
      chk8("reset value", 8'h00, rdVal);
    end
    wr8(ncs_pkg::APPLY_OFS, 8'h01);
    repeat (3) @(posedge mclk);
    #1;
    chk8("apply pulses", 8'h01, applyCnt);
    rd8(ncs_pkg::APPLY_OFS);
    chk8("apply bit", 8'h00, rdVal);
    wr8(ncs_pkg::SAVE_OFS, 8'h01);
    rd8(ncs_pkg::SAVE_OFS);
    chk8("save refused", 8'h00, rdVal);
    chk8("store writes", 8'h00, wrCount);
    for (i = 0; i < 2; i++) begin
      seg[i] = 12'(256 * i + ($unsigned($random(seed)) % 200));
      cnt[i] = 8'(1 + ($unsigned($random(seed)) % 4));
    end
    tot = cnt[0] + cnt[1];
    // Third segment has count 0 and must be skipped
    lst = '{cnt[0], {4'h0, seg[0][11:8]}, seg[0][7:0], cnt[1], {4'h0, seg[1][11:8]},
            seg[1][7:0], 8'h00, 8'h01, 8'h23, ncs_pkg::OP_APPLY, ncs_pkg::OP_END};
    for (i = 0; i < 11; i++) wr8(ncs_pkg::LIST_FIRST_OFS + 12'(i), lst[i]);
    for (i = 0; i < 11; i++) begin
      rd8(ncs_pkg::LIST_FIRST_OFS + 12'(i));
      chk8("list entry", lst[i], rdVal);
    end
    for (i = 0; i < 512; i++) P.bufMem[i] = 8'($random(seed));
    wr8(ncs_pkg::RELOAD_OFS, 8'h01);
    wr8(ncs_pkg::SAVE_OFS, 8'h01);
    rd8(ncs_pkg::SAVE_OFS);
    chk8("save bit busy", 8'h01, rdVal);
    rd8(ncs_pkg::BUSY_OFS);
    chk8("busy bit", 8'h01, rdVal);
    wr8(ncs_pkg::LIST_FIRST_OFS, 8'h55);
    waitIdle();
    rd8(ncs_pkg::SAVE_OFS);
    chk8("save bit done", 8'h00, rdVal);
    rd8(ncs_pkg::LIST_FIRST_OFS);
    chk8("list locked", lst[0], rdVal);
    sum = 8'h00;
    for (i = 0; i < tot; i++) begin
      keep[i] = P.bufMem[srcAddr(i)];
      chk8("store byte", keep[i], P.mem[i]);
      sum = sum + keep[i];
      P.bufMem[srcAddr(i)] = ~keep[i];
    end
    chk8("checksum", sum, P.mem[tot]);
    chk8("save writes", 8'(tot + 1), wrCount);
    chk8("no apply on save", 8'h01, applyCnt);
    storeSelect_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    lat = 2'($random(seed));
    reload();
    rd8(ncs_pkg::RELOAD_OFS);
    chk8("reload bit", 8'h01, rdVal);
    chk8("soft resets", 8'h01, softCnt);
    chk8("apply on load", 8'h02, applyCnt);
    for (i = 0; i < tot; i++) chk8("buffer restored", keep[i], P.bufMem[srcAddr(i)]);
    rd8(ncs_pkg::ERROR_OFS);
    chk8("error clean", 8'h00, rdVal);
    corrupt = 1'b1;
    reload();
    rd8(ncs_pkg::ERROR_OFS);
    chk8("error set", 8'h01, rdVal);
    corrupt = 1'b0;
    storeSelect_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    reload();
    chk8("reload pin high", 8'h02, softCnt);
    storeSelect_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    reload();
    rd8(ncs_pkg::ERROR_OFS);
    chk8("error cleared", 8'h00, rdVal);
    finish_test();
  end
endmodule : tb_ncs_config_store
